/* File: smff_master.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module smff_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  logic [PW:0] count_nxt;
  logic doPush;
  logic doPop;
  logic [PW-1:0] rdPtr_nxt;

  // Handshakes and occupancy
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign count_nxt = count_r + {{PW{1'b0}}, doPush} - {{PW{1'b0}}, doPop};
  assign rdPtr_nxt = doPop ? rdPtr_r + 1'b1 : rdPtr_r;

  // Head word held in its own flop so the read port leaves a register
  // Bypass covers the slot that is written at the same edge
  always_ff @(posedge clk) begin
    if (doPush && (wrPtr_r == rdPtr_nxt)) begin
      outData <= inData;
    end else begin
      outData <= mem[rdPtr_nxt];
    end
  end

  // Storage has no reset; the pointers, count and flags do
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Flags come from the next count so full and empty never lag
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_nxt;
      inReady <= count_nxt != (PW+1)'(DEPTH);
      outValid <= count_nxt != '0;
    end
  end
endmodule

// Operation
// - Control frame always sent; direction picks data
// - Wire start needs control word and slave
// - Master-send direction ends on empty transmit FIFO
// - Nonsequential receive ends when FIFO empty
// - Sequential receive ends at count plus one
// - Handshake: wait slave ready before finishing
// - Handshake: hold next frame until ready
// - Start on one entry once slave enabled
// - Busy cleared when transfer is done
// - Polarity sets idle serial clock level
// - Data frame four to thirty-two bits
// - Phase zero: data valid before first edge
// - Phase zero toggle: select pulses between frames
// - Phase one: drive leading, capture trailing
// - Phase one: frames back to back, select held
// - Mode 00: transmit and store received
// - Mode 01: transmit, discard received
// - Mode 10: dummy start, constant line, store
// - Mode 11: send opcode, then store reads
// - Receive-only ends at count plus one
// - Wire receive skips slave dummy zero bit
// - Control word one to sixteen bits
module smff_master (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterEnable,
  input wire logic [smff_pkg::SLAVE_N-1:0] slaveEnable,
  input wire logic [15:0] clockDivider,
  input wire logic clockPolarity,
  input wire logic clockPhase,
  input wire logic selectToggleEnable,
  input wire logic [1:0] transferModeField,
  input wire logic [4:0] frameSizeM1,
  input wire logic wireProtocolSelect,
  input wire logic [3:0] controlFrameSize,
  input wire logic dataDirection,
  input wire logic sequentialSelect,
  input wire logic handshakeEnable,
  input wire logic [15:0] frameCountField,
  input wire logic [smff_pkg::WORD_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [smff_pkg::WORD_W-1:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic busy,
  output logic txEmpty,
  output logic sclk,
  output logic [smff_pkg::SLAVE_N-1:0] slaveSelectN,
  output logic txd,
  output logic txdOe,
  input wire logic rxd
);
  import smff_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [WORD_W-1:0] txOutData;
  logic txOutValid;
  logic txPop;
  logic [WORD_W-1:0] rxInData;
  logic rxInValid;
  logic rxInReady;
  smff_state_e state_r;
  logic [15:0] divCnt_r;
  logic tick;
  logic lead_r;
  logic [5:0] bitCnt_r;
  logic [4:0] widthM1_r;
  logic [WORD_W-1:0] txWord_r;
  logic [WORD_W-1:0] rxSh_r;
  logic txOn_r;
  logic segData_r;
  logic rxPhase_r;
  logic hsDone_r;
  logic [15:0] frameNo_r;
  logic rxdMeta_r;
  logic rxdSync_r;
  logic cpolE;
  logic cphaE;
  logic [4:0] dataM1;
  logic countHit;
  logic gapNeed;
  logic advance;
  logic doLoad;
  logic sampleNow;
  logic pushReq;
  logic popReq;
  logic loadReq;
  logic loadTx;
  logic loadCtrl;
  logic loadDummy;
  logic setRxPhase;
  logic endReq;
  logic hsReq;
  logic [5:0] loadBits;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] clampBits(input logic [4:0] m1);
    return (m1 < FRAME_M1_MIN) ? FRAME_M1_MIN : m1;
  endfunction

  function automatic logic [WORD_W-1:0] lowMask(input logic [4:0] m1);
    return {WORD_W{1'b1}} >> (FRAME_M1_MAX - m1);
  endfunction

  // Bit cnt-1 of the word, so counting down walks MSB to LSB
  function automatic logic pickBit(input logic [WORD_W-1:0] w, input logic [5:0] cnt);
    logic [5:0] idx;
    idx = cnt - BIT_ONE;
    return w[idx[4:0]];
  endfunction

  function automatic logic [15:0] halfPeriod(input logic [15:0] div);
    logic [15:0] h;
    h = div >> 1;
    return (h == DIV_RST) ? HALF_MIN : h;
  endfunction

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  // Disabling the master empties both queues
  smff_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .clk(clk),
    .rst(rst),
    .flush(!masterEnable),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(txOutData),
    .outValid(txOutValid),
    .outReady(txPop)
  );

  smff_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(clk),
    .rst(rst),
    .flush(!masterEnable),
    .inData(rxInData),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .outData(rxData),
    .outValid(rxValid),
    .outReady(rxReady)
  );

  // ----------------------------------------
  // Format decode
  // ----------------------------------------
  // Wire protocol propagates on falling and captures on rising
  assign cpolE = wireProtocolSelect ? 1'b0 : clockPolarity;
  assign cphaE = wireProtocolSelect ? 1'b0 : clockPhase;
  assign dataM1 = clampBits(frameSizeM1);
  assign countHit = frameNo_r == frameCountField;
  assign gapNeed = !wireProtocolSelect && !cphaE && selectToggleEnable;
  assign tick = divCnt_r == DIV_RST;
  assign sampleNow = tick && (state_r == ST_SHIFT) && (lead_r == cphaE);
  assign advance = (state_r == ST_IDLE) || ((state_r == ST_FEND) && (!pushReq || rxInReady));
  assign doLoad = advance && loadReq && masterEnable;
  assign txPop = doLoad && popReq;
  assign rxInValid = (state_r == ST_FEND) && pushReq && masterEnable;
  assign rxInData = rxSh_r & lowMask(widthM1_r);

  // Next frame length, with the slave dummy bit when present
  always_comb begin
    if (loadCtrl) begin
      loadBits = {2'b00, controlFrameSize} + BIT_ONE;
    end else begin
      loadBits = {1'b0, dataM1} + BIT_ONE + {5'h00, loadDummy};
    end
  end

  // ----------------------------------------
  // Frame sequencing decisions
  // ----------------------------------------
  always_comb begin
    pushReq = 1'b0;
    popReq = 1'b0;
    loadReq = 1'b0;
    loadTx = 1'b0;
    loadCtrl = 1'b0;
    loadDummy = 1'b0;
    setRxPhase = 1'b0;
    endReq = 1'b0;
    hsReq = 1'b0;
    if (state_r == ST_IDLE) begin
      // Any slave plus one entry starts; the entry may be a dummy
      loadReq = txOutValid && (slaveEnable != '0);
      popReq = loadReq;
      loadCtrl = wireProtocolSelect;
      loadTx = wireProtocolSelect || (transferModeField != MODE_RXONLY);
    end else if (wireProtocolSelect) begin
      if (!segData_r) begin
        if (dataDirection) begin
          // Control only when no data word follows
          loadReq = txOutValid;
          popReq = txOutValid;
          loadTx = 1'b1;
          hsReq = !txOutValid && handshakeEnable && !hsDone_r;
          endReq = !txOutValid;
        end else begin
          loadReq = 1'b1;
          loadDummy = 1'b1;
        end
      end else if (dataDirection) begin
        hsReq = handshakeEnable && !hsDone_r;
        loadReq = !hsReq && txOutValid;
        popReq = loadReq;
        loadTx = 1'b1;
        loadCtrl = 1'b1;
        endReq = !hsReq && !txOutValid;
      end else begin
        pushReq = 1'b1;
        if (sequentialSelect) begin
          endReq = countHit;
          loadReq = !countHit;
        end else begin
          loadReq = txOutValid;
          popReq = txOutValid;
          loadTx = 1'b1;
          loadCtrl = 1'b1;
          endReq = !txOutValid;
        end
      end
    end else begin
      unique case (transferModeField)
        MODE_TXRX: begin
          pushReq = 1'b1;
          loadReq = txOutValid;
          popReq = txOutValid;
          loadTx = 1'b1;
          endReq = !txOutValid;
        end
        MODE_TXONLY: begin
          loadReq = txOutValid;
          popReq = txOutValid;
          loadTx = 1'b1;
          endReq = !txOutValid;
        end
        MODE_RXONLY: begin
          pushReq = 1'b1;
          endReq = countHit;
          loadReq = !countHit;
        end
        MODE_EEPROM: begin
          if (!rxPhase_r) begin
            // Opcode and address bits are shifted in but never stored
            loadReq = 1'b1;
            popReq = txOutValid;
            loadTx = txOutValid;
            setRxPhase = !txOutValid;
          end else begin
            pushReq = 1'b1;
            endReq = countHit;
            loadReq = !countHit;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial clock divider
  // ----------------------------------------
  // Free running; restarted in idle so the first half bit is full
  always_ff @(posedge clk) begin
    if (rst || (state_r == ST_IDLE) || tick) begin
      divCnt_r <= halfPeriod(clockDivider) - HALF_MIN;
    end else begin
      divCnt_r <= divCnt_r - HALF_MIN;
    end
  end

  // ----------------------------------------
  // Receive line
  // ----------------------------------------
  // Two stages before use; the pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      rxdMeta_r <= 1'b0;
      rxdSync_r <= 1'b0;
    end else begin
      rxdMeta_r <= rxd;
      rxdSync_r <= rxdMeta_r;
    end
  end

  // Shift in at the capture edge, MSB arrives first
  always_ff @(posedge clk) begin
    if (rst) begin
      rxSh_r <= WORD_RST;
    end else if (sampleNow) begin
      rxSh_r <= {rxSh_r[WORD_W-2:0], rxdSync_r};
    end
  end

  // Received frame count for count-terminated transfers
  always_ff @(posedge clk) begin
    if (rst || ((state_r == ST_IDLE) && doLoad)) begin
      frameNo_r <= FRAMES_RST;
    end else if (rxInValid && rxInReady) begin
      frameNo_r <= frameNo_r + COUNT_STEP;
    end
  end

  // ----------------------------------------
  // Frame setup
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      txWord_r <= WORD_RST;
      txOn_r <= 1'b0;
      segData_r <= 1'b0;
      rxPhase_r <= 1'b0;
      hsDone_r <= 1'b0;
      widthM1_r <= FRAME_M1_MIN;
    end else if (doLoad) begin
      txWord_r <= txOutData;
      txOn_r <= loadTx;
      segData_r <= !loadCtrl;
      rxPhase_r <= ((state_r == ST_IDLE) ? 1'b0 : rxPhase_r) || setRxPhase;
      hsDone_r <= 1'b0;
      widthM1_r <= loadCtrl ? {1'b0, controlFrameSize} : dataM1;
    end else if ((state_r == ST_HSWAIT) && rxdSync_r) begin
      hsDone_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Shift engine and pins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      sclk <= SCLK_RST;
      slaveSelectN <= SEL_IDLE;
      txd <= TXD_IDLE;
      txdOe <= 1'b0;
      busy <= 1'b0;
      txEmpty <= 1'b1;
      lead_r <= 1'b0;
      bitCnt_r <= BITS_RST;
    end else begin
      txEmpty <= !txOutValid;
      if (doLoad) begin
        // Phase zero needs the MSB on the line before the first edge
        txd <= loadTx ? pickBit(txOutData, loadBits) : TXD_IDLE;
        bitCnt_r <= loadBits;
        lead_r <= 1'b0;
      end
      if (!masterEnable) begin
        state_r <= ST_IDLE;
        sclk <= cpolE;
        slaveSelectN <= SEL_IDLE;
        txdOe <= 1'b0;
        busy <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            sclk <= cpolE;
            if (doLoad) begin
              busy <= 1'b1;
              txdOe <= 1'b1;
              slaveSelectN <= ~slaveEnable;
              state_r <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (tick && !lead_r) begin
              sclk <= ~cpolE;
              lead_r <= 1'b1;
              if (cphaE) begin
                txd <= txOn_r ? pickBit(txWord_r, bitCnt_r) : TXD_IDLE;
              end
            end else if (tick) begin
              sclk <= cpolE;
              lead_r <= 1'b0;
              bitCnt_r <= bitCnt_r - BIT_ONE;
              if (bitCnt_r == BIT_ONE) begin
                state_r <= ST_FEND;
              end else if (!cphaE) begin
                txd <= txOn_r ? pickBit(txWord_r, bitCnt_r - BIT_ONE) : TXD_IDLE;
              end
            end
          end
          ST_FEND: begin
            // Stalls here while the receive FIFO is full and the finished frame is one to be stored
            if (advance && doLoad) begin
              state_r <= gapNeed ? ST_GAP : ST_SHIFT;
              if (gapNeed) begin
                slaveSelectN <= SEL_IDLE;
              end
            end else if (advance && hsReq) begin
              state_r <= ST_HSWAIT;
            end else if (advance && endReq) begin
              state_r <= ST_DONE;
            end
          end
          ST_GAP: begin
            if (tick) begin
              slaveSelectN <= ~slaveEnable;
              state_r <= ST_SHIFT;
            end
          end
          ST_HSWAIT: begin
            // Select stays low while the slave reports busy
            if (rxdSync_r) begin
              state_r <= ST_FEND;
            end
          end
          ST_DONE: begin
            if (tick) begin
              slaveSelectN <= SEL_IDLE;
              txdOe <= 1'b0;
              busy <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

/* File: smff_master_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module smff_master_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic masterEnable,
  input wire logic [smff_pkg::SLAVE_N-1:0] slaveEnable,
  input wire logic clockPolarity,
  input wire logic wireProtocolSelect,
  input wire logic [1:0] transferModeField,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic busy,
  input wire logic txEmpty,
  input wire logic sclk,
  input wire logic [smff_pkg::SLAVE_N-1:0] slaveSelectN,
  input wire logic txd,
  input wire logic txdOe
);
  import smff_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Idle pins; enable history guards the cycle after a re-enable
  a_idle_clock_level: assert property (
    !busy && masterEnable && $past(masterEnable) && !$past(rst)
    |-> sclk == (clockPolarity && !wireProtocolSelect))
    else $error("sclk off idle level");
  a_idle_select_high: assert property (!busy |-> slaveSelectN == SEL_IDLE)
    else $error("select active while idle");
  a_oe_follows_busy: assert property (txdOe == busy)
    else $error("txdOe differs from busy");
  a_start_needs_slave: assert property (
    $rose(busy) |-> $past(masterEnable) && $past(slaveEnable) != 4'h0)
    else $error("start without enable or slave");
  a_select_maps_enable: assert property (
    busy && slaveSelectN != SEL_IDLE |-> slaveSelectN == ~slaveEnable)
    else $error("wrong select pattern");
  a_abort_idles_pins: assert property (
    !masterEnable |=> !busy && slaveSelectN == SEL_IDLE)
    else $error("disable did not idle");
  a_rxonly_const_line: assert property (
    busy && !wireProtocolSelect && transferModeField == MODE_RXONLY |-> txd == TXD_IDLE)
    else $error("txd moved in receive only");
  a_gap_clock_idle: assert property (
    busy && slaveSelectN == SEL_IDLE |-> sclk == clockPolarity)
    else $error("sclk moved with select high");
  a_first_edge_later: assert property (
    $rose(busy) |-> sclk == clockPolarity ##1 slaveSelectN != SEL_IDLE)
    else $error("select not ahead of clock");
  a_reset_outputs: assert property (
    $past(rst) |-> txReady && txEmpty && !rxValid && !busy)
    else $error("bad state after reset");
  // Main scenarios reached
  c_wire_start: cover property ($rose(busy) && wireProtocolSelect);
  c_rx_stored: cover property (busy && rxValid);
  c_select_gap: cover property (busy && slaveSelectN == SEL_IDLE);
endmodule

bind smff_master smff_master_monitor u_mon (
  .clk(clk), .rst(rst), .masterEnable(masterEnable), .slaveEnable(slaveEnable),
  .clockPolarity(clockPolarity), .wireProtocolSelect(wireProtocolSelect),
  .transferModeField(transferModeField), .txReady(txReady), .rxValid(rxValid),
  .busy(busy), .txEmpty(txEmpty), .sclk(sclk), .slaveSelectN(slaveSelectN),
  .txd(txd), .txdOe(txdOe)
);
`default_nettype wire

/* File: smff_pkg.sv */
`default_nettype none

package smff_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int SLAVE_N = 4;

  // ----------------------------------------
  // Transfer mode encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_TXRX = 2'h0;
  localparam logic [1:0] MODE_TXONLY = 2'h1;
  localparam logic [1:0] MODE_RXONLY = 2'h2;
  localparam logic [1:0] MODE_EEPROM = 2'h3;

  // ----------------------------------------
  // Frame, divider and counting constants
  // ----------------------------------------
  localparam logic [4:0] FRAME_M1_MIN = 5'h03;
  localparam logic [4:0] FRAME_M1_MAX = 5'h1f;
  localparam logic [5:0] BIT_ONE = 6'h01;
  localparam logic [15:0] HALF_MIN = 16'h0001;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // ----------------------------------------
  // Values after reset and idle levels
  // ----------------------------------------
  localparam logic [SLAVE_N-1:0] SEL_IDLE = 4'hf;
  localparam logic TXD_IDLE = 1'b0;
  localparam logic SCLK_RST = 1'b0;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] FRAMES_RST = 16'h0000;
  localparam logic [5:0] BITS_RST = 6'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------
  // Shift engine states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SHIFT = 6'b000010,
    ST_FEND = 6'b000100,
    ST_GAP = 6'b001000,
    ST_HSWAIT = 6'b010000,
    ST_DONE = 6'b100000
  } smff_state_e;

endpackage

`default_nettype wire

/* File: smff_slave_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Serial slave, polarity 0 phase 0, 8-bit
// ----------------------------------------
module smff_slave_model #(
  parameter logic [7:0] RESP = 8'ha5
) (
  input wire logic sclk,
  input wire logic selN,
  input wire logic txd,
  input wire logic hsMode,
  input wire logic hsReady,
  output logic rxd,
  output logic [7:0] got,
  output logic [15:0] frames
);
  logic [7:0] sh = RESP;
  logic [7:0] cap = 8'h00;
  logic [3:0] n = 4'h0;
  logic held = 1'b0;
  logic drv;
  initial begin
    got = 8'h00;
    frames = 16'h0000;
  end
  // MSB out as select falls, ahead of the first edge
  always @(negedge selN) begin
    n = 4'h0;
    sh = RESP;
  end
  // Capture on leading edge, MSB first
  always @(posedge sclk) begin
    if (!selN) begin
      cap = {cap[6:0], txd};
      n = n + 4'h1;
      if (n == 4'h8) begin
        got = cap;
        frames = frames + 16'h0001;
        n = 4'h0;
      end
    end
  end
  // Shift on trailing edge; reload at frame boundary
  always @(negedge sclk) begin
    if (!selN) begin
      sh = (n == 4'h0) ? RESP : {sh[6:0], 1'b0};
    end
  end
  // Ready shown on the line only in handshake runs
  assign drv = hsMode ? hsReady : sh[7];
  // Released line drifts, so stale data cannot pass
  always @(posedge selN) begin
    held = ~drv;
  end
  assign rxd = selN ? held : drv;
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Testbench
// ----------------------------------------
module testbench;
  import smff_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic masterEnable = 1'b1;
  logic [3:0] slaveEnable = 4'h1;
  logic [15:0] clockDivider = 16'h0010;
  logic clockPolarity = 1'b0;
  logic clockPhase = 1'b0;
  logic selectToggleEnable = 1'b0;
  logic [1:0] transferModeField = 2'h0;
  logic [4:0] frameSizeM1 = 5'h07;
  logic wireProtocolSelect = 1'b0;
  logic [3:0] controlFrameSize = 4'h0;
  logic dataDirection = 1'b1;
  logic sequentialSelect = 1'b0;
  logic handshakeEnable = 1'b0;
  logic [15:0] frameCountField = 16'h0000;
  logic [31:0] txData = 32'h0;
  logic txValid = 1'b0;
  logic rxReady = 1'b0;
  logic hsMode = 1'b0;
  logic hsReady = 1'b0;
  logic txReady, rxValid, busy, txEmpty, sclk, txd, txdOe, rxd;
  logic [31:0] rxData;
  logic [3:0] slaveSelectN;
  logic [7:0] got;
  logic [15:0] frames;
  logic [15:0] f0;
  int badCount = 0;
  int nCompared = 0;

  smff_master dut (
    .clk(clk), .rst(rst), .masterEnable(masterEnable), .slaveEnable(slaveEnable),
    .clockDivider(clockDivider), .clockPolarity(clockPolarity), .clockPhase(clockPhase),
    .selectToggleEnable(selectToggleEnable), .transferModeField(transferModeField),
    .frameSizeM1(frameSizeM1), .wireProtocolSelect(wireProtocolSelect),
    .controlFrameSize(controlFrameSize), .dataDirection(dataDirection),
    .sequentialSelect(sequentialSelect), .handshakeEnable(handshakeEnable),
    .frameCountField(frameCountField), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .busy(busy), .txEmpty(txEmpty), .sclk(sclk), .slaveSelectN(slaveSelectN),
    .txd(txd), .txdOe(txdOe), .rxd(rxd)
  );
  smff_slave_model slave (
    .sclk(sclk), .selN(slaveSelectN[0]), .txd(txd), .hsMode(hsMode),
    .hsReady(hsReady), .rxd(rxd), .got(got), .frames(frames)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Valid held until an edge samples ready high
  task automatic push(input logic [31:0] w);
    @(negedge clk);
    txData = w;
    txValid = 1'b1;
    while (txReady !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic pop(input logic [31:0] e);
    int i;
    i = 0;
    @(negedge clk);
    while (rxValid !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    check(32'(rxValid), 32'h1);
    check(rxData, e);
    rxReady = 1'b1;
    @(negedge clk);
    rxReady = 1'b0;
  endtask

  // Busy is not valid right after loading, so settle first
  task automatic waitDone(input logic [15:0] nf);
    int i;
    i = 0;
    @(negedge clk);
    txValid = 1'b0;
    repeat (4) @(negedge clk);
    while (busy !== 1'b0 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    check(32'(busy), 32'h0);
    check(32'(txEmpty), 32'h1);
    check(32'(frames - f0), 32'(nf));
    f0 = frames;
  endtask

  // Reconfigure only while disabled; the caller enables again
  task automatic cfg(input logic [1:0] m, input logic [15:0] cnt, input logic wp);
    @(negedge clk);
    masterEnable = 1'b0;
    transferModeField = m;
    frameCountField = cnt;
    wireProtocolSelect = wp;
    @(negedge clk);
  endtask

  // Watchdog sized well past the longest sequence
  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    endOfTest();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    f0 = frames;
    cfg(MODE_TXRX, 16'h0, 1'b0);
    selectToggleEnable = 1'b1;
    slaveEnable = 4'h0;
    masterEnable = 1'b1;
    for (int k = 0; k < FIFO_DEPTH; k++) push(32'h40 + k);
    @(negedge clk);
    txValid = 1'b0;
    @(negedge clk);
    check(32'(txReady), 32'h0);
    repeat (50) @(negedge clk);
    check(32'(busy), 32'h0);
    slaveEnable = 4'h1;
    waitDone(16'h10);
    check({24'h0, got}, 32'h4f);
    for (int k = 0; k < FIFO_DEPTH; k++) pop(32'ha5);
    check(32'(rxValid), 32'h0);
    $display("test fill_txrx done");
    cfg(MODE_TXONLY, 16'h0, 1'b0);
    masterEnable = 1'b1;
    push(32'h81);
    waitDone(16'h1);
    check({24'h0, got}, 32'h81);
    check(32'(rxValid), 32'h0);
    $display("test tx_only done");
    cfg(MODE_RXONLY, 16'h2, 1'b0);
    masterEnable = 1'b1;
    push(32'hff);
    waitDone(16'h3);
    check({24'h0, got}, 32'h0);
    for (int k = 0; k < 3; k++) pop(32'ha5);
    check(32'(rxValid), 32'h0);
    $display("test rx_only done");
    cfg(MODE_EEPROM, 16'h1, 1'b0);
    masterEnable = 1'b1;
    push(32'h03);
    push(32'h10);
    waitDone(16'h4);
    for (int k = 0; k < 2; k++) pop(32'ha5);
    check(32'(rxValid), 32'h0);
    $display("test eeprom_read done");
    cfg(MODE_TXRX, 16'h0, 1'b1);
    controlFrameSize = 4'h3;
    handshakeEnable = 1'b1;
    clockDivider = 16'h0014;
    hsMode = 1'b1;
    masterEnable = 1'b1;
    push(32'ha);
    push(32'h5a);
    @(negedge clk);
    txValid = 1'b0;
    repeat (700) @(negedge clk);
    check(32'(busy), 32'h1);
    check({24'h0, got}, 32'ha5);
    hsReady = 1'b1;
    waitDone(16'h1);
    $display("test wire_handshake done");
    // Slave streams a5; after 4 control bits and the dummy the data reads b4
    cfg(MODE_TXRX, 16'h1, 1'b1);
    dataDirection = 1'b0;
    sequentialSelect = 1'b1;
    hsMode = 1'b0;
    masterEnable = 1'b1;
    push(32'h6);
    waitDone(16'h2);
    for (int k = 0; k < 2; k++) pop(32'hb4);
    check(32'(rxValid), 32'h0);
    $display("test wire_seq_read done");
    endOfTest();
  end
endmodule
`default_nettype wire
